//--- pkg/apf_cfg.svh
`ifndef APF_CFG_SVH
`define APF_CFG_SVH

`define APF_OFF_CTRL 8'h00
`define APF_OFF_OPA 8'h04
`define APF_OFF_OPB 8'h08
`define APF_OFF_PC 8'h0c
`define APF_OFF_SREG 8'h10
`define APF_OFF_ZPTR 8'h14
`define APF_OFF_PROD 8'h18
`define APF_OFF_STAT 8'h1c

`define APF_CTRL_OP_MSB 5
`define APF_CTRL_LONG_BIT 8
`define APF_CTRL_GO_BIT 9

`define APF_STAT_BUSY_BIT 0
`define APF_STAT_ERR_BIT 1

`define APF_FLAG_C 0
`define APF_FLAG_Z 1
`define APF_FLAG_N 2
`define APF_FLAG_V 3
`define APF_FLAG_S 4
`define APF_FLAG_H 5
`define APF_FLAG_I 7

`define APF_SREG_RST 8'h00
`define APF_WORD_RST 16'h0000

`define APF_STACK_DEPTH 8
`define APF_SP_W 4

`define APF_CYC_ONE 3'd1
`define APF_CYC_TWO 3'd2
`define APF_CYC_THREE 3'd3
`define APF_CYC_FOUR 3'd4

`endif

//--- pkg/apf_pkg.sv
`default_nettype none
`include "apf_cfg.svh"
package apf_pkg;

	typedef enum logic [5:0] {
		op_add, op_add_carry, op_word_add_immediate,
		op_subtract, op_subtract_constant, op_subtract_with_borrow,
		op_subtract_constant_with_borrow, op_word_subtract_immediate,
		op_and, op_and_with_constant, op_or, op_or_with_constant,
		op_exclusive_or_registers, op_bitwise_invert, op_arithmetic_negate,
		op_set_bits_masked, op_clear_bits_masked, op_increment,
		op_decrement, op_zero_sign_test, op_zero_register,
		op_all_ones_register, op_product_unsigned, op_product_signed,
		op_product_signed_by_unsigned, op_fraction_product_unsigned,
		op_fraction_product_signed, op_fraction_product_mixed,
		op_relative_jump, op_pointer_jump, op_absolute_jump,
		op_relative_subroutine_invoke, op_pointer_subroutine_invoke,
		op_absolute_subroutine_invoke, op_subroutine_exit,
		op_interrupt_exit, op_equal_skip, op_compare_registers,
		op_compare_with_borrow
	} apf_op_t;

	typedef enum logic {st_idle, st_busy} apf_st_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apf_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apf_apb_rsp_t;

	typedef struct packed {
		logic [15:0] opa;
		logic [15:0] opb;
		logic [15:0] pc;
		logic [15:0] zptr;
		logic [15:0] prod;
		logic [7:0] sreg;
		logic [`APF_STACK_DEPTH-1:0][15:0] stack;
		logic [`APF_SP_W-1:0] sp;
		logic stack_err;
		logic [2:0] cnt;
		logic [2:0] last_cyc;
		logic [5:0] last_op;
		apf_st_t st;
		apf_apb_rsp_t rsp;
	} apf_regs_t;

endpackage : apf_pkg
`default_nettype wire

//--- logic/apf_core.sv
`default_nettype none
`include "apf_cfg.svh"
module apf_core (
	input wire logic pclk,
	input wire logic presetn,
	input wire apf_pkg::apf_apb_req_t apb_req,
	output var apf_pkg::apf_apb_rsp_t apb_rsp,
	output logic busy,
	output logic global_int_en
);
	import apf_pkg::*;

	apf_regs_t s_q;
	apf_regs_t s_d;

	logic acc;
	logic wr;
	logic go;
	apf_op_t op;
	logic [7:0] d8;
	logic [7:0] r8;
	logic cin;
	logic use_c;
	logic [8:0] sum9;
	logic [4:0] hsum;
	logic [8:0] dif9;
	logic [4:0] hdif;
	logic [16:0] wsum;
	logic [16:0] wdif;
	logic signed [17:0] p18;
	logic [15:0] p16;
	logic [7:0] res;
	logic [7:0] nf;
	logic [7:0] mask;
	logic [2:0] cyc;
	logic [15:0] ret_addr;
	logic push;
	logic pop;
	logic [31:0] rd;
	logic rd_err;

	always_comb begin
		s_d = s_q;
		acc = apb_req.psel & apb_req.penable & s_q.rsp.pready;
		wr = acc & apb_req.pwrite;
		op = apf_op_t'(apb_req.pwdata[`APF_CTRL_OP_MSB:0]);
		go = wr & (apb_req.paddr == `APF_OFF_CTRL) &
			apb_req.pwdata[`APF_CTRL_GO_BIT] & (s_q.st == st_idle);
		d8 = s_q.opa[7:0];
		r8 = s_q.opb[7:0];
		cin = s_q.sreg[`APF_FLAG_C];
		use_c = (op == op_add_carry) | (op == op_subtract_with_borrow) |
			(op == op_subtract_constant_with_borrow) |
			(op == op_compare_with_borrow);
		sum9 = {1'b0, d8} + {1'b0, r8} + {8'h00, use_c & cin};
		hsum = {1'b0, d8[3:0]} + {1'b0, r8[3:0]} + {4'h0, use_c & cin};
		dif9 = {1'b0, d8} - {1'b0, r8} - {8'h00, use_c & cin};
		hdif = {1'b0, d8[3:0]} - {1'b0, r8[3:0]} - {4'h0, use_c & cin};
		wsum = {1'b0, s_q.opa} + {11'h000, s_q.opb[5:0]};
		wdif = {1'b0, s_q.opa} - {11'h000, s_q.opb[5:0]};
		p18 = $signed({d8[7] & (op == op_product_signed |
			op == op_product_signed_by_unsigned |
			op == op_fraction_product_signed |
			op == op_fraction_product_mixed), d8}) *
			$signed({r8[7] & (op == op_product_signed |
			op == op_fraction_product_signed), r8});
		p16 = p18[15:0];
		res = d8;
		nf = 8'h00;
		mask = 8'h00;
		cyc = `APF_CYC_ONE;
		ret_addr = s_q.pc + 16'h0001;
		push = 1'b0;
		pop = 1'b0;

		// shared flag forms for 8-bit subtract and compare
		nf[`APF_FLAG_C] = dif9[8];
		nf[`APF_FLAG_H] = hdif[4];
		nf[`APF_FLAG_V] = (d8[7] & ~r8[7] & ~dif9[7]) |
			(~d8[7] & r8[7] & dif9[7]);

		if (go) begin
			s_d.pc = s_q.pc + 16'h0001;
			case (op)
				op_add, op_add_carry: begin
					res = sum9[7:0];
					mask = 8'h2f;
					nf[`APF_FLAG_C] = sum9[8];
					nf[`APF_FLAG_H] = hsum[4];
					nf[`APF_FLAG_V] = (d8[7] & r8[7] & ~sum9[7]) |
						(~d8[7] & ~r8[7] & sum9[7]);
				end
				op_subtract, op_subtract_constant: begin
					res = dif9[7:0];
					mask = 8'h2f;
				end
				op_compare_registers: begin
					res = dif9[7:0];
					mask = 8'h2f;
				end
				op_subtract_with_borrow, op_subtract_constant_with_borrow,
				op_compare_with_borrow: begin
					res = dif9[7:0];
					mask = 8'h2f;
				end
				op_word_add_immediate, op_word_subtract_immediate: begin
					cyc = `APF_CYC_TWO;
					mask = 8'h1f;
					if (op == op_word_add_immediate) begin
						s_d.opa = wsum[15:0];
						nf[`APF_FLAG_V] = ~s_q.opa[15] & wsum[15];
						nf[`APF_FLAG_C] = s_q.opa[15] & ~wsum[15];
					end else begin
						s_d.opa = wdif[15:0];
						nf[`APF_FLAG_V] = s_q.opa[15] & ~wdif[15];
						nf[`APF_FLAG_C] = ~s_q.opa[15] & wdif[15];
					end
				end
				op_and, op_and_with_constant: begin
					res = d8 & r8;
					mask = 8'h0e;
				end
				op_or, op_or_with_constant: begin
					res = d8 | r8;
					mask = 8'h0e;
				end
				op_exclusive_or_registers: begin
					res = d8 ^ r8;
					mask = 8'h0e;
				end
				op_set_bits_masked: begin
					res = d8 | r8;
					mask = 8'h0e;
				end
				op_clear_bits_masked: begin
					res = d8 & (8'hff - r8);
					mask = 8'h0e;
				end
				op_zero_sign_test: begin
					res = d8 & d8;
					mask = 8'h0e;
				end
				op_bitwise_invert: begin
					res = 8'hff - d8;
					mask = 8'h0f;
					nf[`APF_FLAG_C] = 1'b1;
				end
				op_arithmetic_negate: begin
					res = 8'h00 - d8;
					mask = 8'h2f;
					nf[`APF_FLAG_C] = (res != 8'h00);
					nf[`APF_FLAG_H] = res[3] | d8[3];
				end
				op_increment: begin
					res = d8 + 8'h01;
					mask = 8'h0e;
				end
				op_decrement: begin
					res = d8 - 8'h01;
					mask = 8'h0e;
				end
				op_zero_register: begin
					res = d8 ^ d8;
					mask = 8'h0e;
				end
				op_all_ones_register: begin
					res = 8'hff;
				end
				op_product_unsigned, op_product_signed,
				op_product_signed_by_unsigned: begin
					s_d.prod = p16;
					cyc = `APF_CYC_TWO;
					mask = 8'h03;
				end
				op_fraction_product_unsigned, op_fraction_product_signed,
				op_fraction_product_mixed: begin
					s_d.prod = {p16[14:0], 1'b0};
					cyc = `APF_CYC_TWO;
					mask = 8'h03;
				end
				op_relative_jump: begin
					s_d.pc = s_q.pc + s_q.opb + 16'h0001;
					cyc = `APF_CYC_TWO;
				end
				op_pointer_jump: begin
					s_d.pc = s_q.zptr;
					cyc = `APF_CYC_TWO;
				end
				op_absolute_jump: begin
					s_d.pc = s_q.opb;
					cyc = `APF_CYC_THREE;
				end
				op_relative_subroutine_invoke: begin
					s_d.pc = s_q.pc + s_q.opb + 16'h0001;
					cyc = `APF_CYC_THREE;
					push = 1'b1;
				end
				op_pointer_subroutine_invoke: begin
					s_d.pc = s_q.zptr;
					cyc = `APF_CYC_THREE;
					push = 1'b1;
				end
				op_absolute_subroutine_invoke: begin
					s_d.pc = s_q.opb;
					ret_addr = s_q.pc + 16'h0002;
					cyc = `APF_CYC_FOUR;
					push = 1'b1;
				end
				op_subroutine_exit, op_interrupt_exit: begin
					cyc = `APF_CYC_FOUR;
					pop = 1'b1;
					if (op == op_interrupt_exit) begin
						s_d.sreg[`APF_FLAG_I] = 1'b1;
					end
				end
				op_equal_skip: begin
					if (d8 == r8) begin
						if (apb_req.pwdata[`APF_CTRL_LONG_BIT]) begin
							s_d.pc = s_q.pc + 16'h0003;
							cyc = `APF_CYC_THREE;
						end else begin
							s_d.pc = s_q.pc + 16'h0002;
							cyc = `APF_CYC_TWO;
						end
					end
				end
				default: begin
				end
			endcase

			if (mask[`APF_FLAG_C] & ~mask[`APF_FLAG_N]) begin
				nf[`APF_FLAG_Z] = (s_d.prod == 16'h0000);
				nf[`APF_FLAG_C] = p16[15];
			end else if (mask[`APF_FLAG_S]) begin
				nf[`APF_FLAG_Z] = (s_d.opa == 16'h0000);
				nf[`APF_FLAG_N] = s_d.opa[15];
				nf[`APF_FLAG_S] = s_d.opa[15] ^ nf[`APF_FLAG_V];
			end else begin
				nf[`APF_FLAG_Z] = (res == 8'h00);
				nf[`APF_FLAG_N] = res[7];
				if (use_c & (op != op_add_carry)) begin
					nf[`APF_FLAG_Z] = (res == 8'h00) & s_q.sreg[`APF_FLAG_Z];
				end
				case (op)
					op_and, op_and_with_constant, op_or, op_or_with_constant,
					op_exclusive_or_registers, op_set_bits_masked,
					op_clear_bits_masked, op_zero_sign_test,
					op_zero_register, op_bitwise_invert:
						nf[`APF_FLAG_V] = 1'b0;
					op_increment, op_arithmetic_negate:
						nf[`APF_FLAG_V] = (res == 8'h80);
					op_decrement:
						nf[`APF_FLAG_V] = (res == 8'h7f);
					default: begin
					end
				endcase
			end
			s_d.sreg = (s_d.sreg & ~mask) | (nf & mask);
			if (mask[`APF_FLAG_H] | (mask[`APF_FLAG_N] & ~mask[`APF_FLAG_S])
				| (op == op_all_ones_register)) begin
				if (op != op_compare_registers &&
					op != op_compare_with_borrow) begin
					s_d.opa[7:0] = res;
				end
			end

			if (push) begin
				if (s_q.sp == `APF_SP_W'(`APF_STACK_DEPTH)) begin
					s_d.stack_err = 1'b1;
				end else begin
					s_d.stack[s_q.sp[`APF_SP_W-2:0]] = ret_addr;
					s_d.sp = s_q.sp + `APF_SP_W'(1);
				end
			end
			if (pop) begin
				if (s_q.sp == `APF_SP_W'(0)) begin
					s_d.stack_err = 1'b1;
					s_d.pc = `APF_WORD_RST;
				end else begin
					s_d.pc = s_q.stack[s_q.sp[`APF_SP_W-2:0] - 3'd1];
					s_d.sp = s_q.sp - `APF_SP_W'(1);
				end
			end
			s_d.last_op = apb_req.pwdata[`APF_CTRL_OP_MSB:0];
			s_d.last_cyc = cyc;
			s_d.cnt = cyc - 3'd1;
		end else if (s_q.cnt != 3'd0) begin
			s_d.cnt = s_q.cnt - 3'd1;
		end
		s_d.st = (s_d.cnt != 3'd0) ? st_busy : st_idle;

		// register writes other than the control word
		if (wr) begin
			case (apb_req.paddr)
				`APF_OFF_OPA: s_d.opa = apb_req.pwdata[15:0];
				`APF_OFF_OPB: s_d.opb = apb_req.pwdata[15:0];
				`APF_OFF_PC: s_d.pc = apb_req.pwdata[15:0];
				`APF_OFF_SREG: s_d.sreg = apb_req.pwdata[7:0];
				`APF_OFF_ZPTR: s_d.zptr = apb_req.pwdata[15:0];
				`APF_OFF_STAT: begin
					if (apb_req.pwdata[`APF_STAT_ERR_BIT]) begin
						s_d.stack_err = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end

		rd = 32'h0000_0000;
		rd_err = 1'b0;
		case (apb_req.paddr)
			`APF_OFF_CTRL: rd = {26'h000_0000, s_q.last_op};
			`APF_OFF_OPA: rd = {16'h0000, s_q.opa};
			`APF_OFF_OPB: rd = {16'h0000, s_q.opb};
			`APF_OFF_PC: rd = {16'h0000, s_q.pc};
			`APF_OFF_SREG: rd = {24'h00_0000, s_q.sreg};
			`APF_OFF_ZPTR: rd = {16'h0000, s_q.zptr};
			`APF_OFF_PROD: rd = {16'h0000, s_q.prod};
			`APF_OFF_STAT: rd = {21'h00_0000, s_q.last_cyc,
				(`APF_SP_W)'(s_q.sp), 2'b00, s_q.stack_err,
				s_q.st == st_busy};
			default: rd_err = 1'b1;
		endcase
		s_d.rsp.pready = apb_req.psel & apb_req.penable & ~s_q.rsp.pready;
		s_d.rsp.pslverr = s_d.rsp.pready & rd_err;
		s_d.rsp.prdata = s_d.rsp.pready ? rd : 32'h0000_0000;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.sreg <= `APF_SREG_RST;
			s_q.st <= st_idle;
		end else begin
			s_q <= s_d;
		end
	end

	assign apb_rsp = s_q.rsp;
	assign busy = s_q.st;
	assign global_int_en = s_q.sreg[`APF_FLAG_I];

endmodule : apf_core
`default_nettype wire

//--- sim/apf_core_asserts.sv
`default_nettype none
module apf_core_asserts (
	input wire logic pclk,
	input wire logic presetn,
	input wire apf_pkg::apf_apb_req_t apb_req,
	input wire apf_pkg::apf_apb_rsp_t apb_rsp,
	input wire logic busy,
	input wire logic global_int_en
);
	import apf_pkg::*;
	logic acc;
	logic go;
	logic [5:0] op;
	assign acc = apb_req.psel && apb_req.penable;
	assign op = apb_req.pwdata[5:0];
	assign go = acc && apb_rsp.pready && apb_req.pwrite &&
		apb_req.paddr == 8'h00 && apb_req.pwdata[9] && !busy;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	rdy_wait_a: assert property (acc && !apb_rsp.pready |=> apb_rsp.pready)
		else $error("pready late");
	rdy_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
		else $error("pready too long");
	rdy_cause_a: assert property (apb_rsp.pready |-> $past(acc))
		else $error("pready without access");
	err_pair_a: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
		else $error("pslverr without pready");
	rdata_idle_a: assert property (!apb_rsp.pready |-> apb_rsp.prdata == '0)
		else $error("prdata not zero");
	one_cyc_a: assert property (
		go && op inside {0, 1, 3, 8, 12} |=> !busy)
		else $error("one cycle op busy");
	two_cyc_a: assert property (
		go && op inside {2, 7, [22:29]} |=> busy ##1 !busy)
		else $error("two cycle op wrong");
	three_cyc_a: assert property (
		go && op inside {[30:32]} |=> busy[*2] ##1 !busy)
		else $error("three cycle op wrong");
	four_cyc_a: assert property (
		go && op inside {[33:35]} |=> busy[*3] ##1 !busy)
		else $error("four cycle op wrong");
	int_en_a: assert property (
		go && op == 6'd35 |=> global_int_en)
		else $error("enable not set");
	flow_keep_a: assert property (
		go && op inside {[28:33]} |=> $stable(global_int_en))
		else $error("flow op changed flag");
endmodule : apf_core_asserts
bind apf_core apf_core_asserts apf_core_asserts_i (.pclk(pclk),
	.presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .busy(busy),
	.global_int_en(global_int_en));
`default_nettype wire

//--- sim/apf_apb_master.sv
`default_nettype none
module apf_apb_master (
	input wire logic pclk,
	input wire apf_pkg::apf_apb_rsp_t apb_rsp,
	output var apf_pkg::apf_apb_req_t apb_req
);
	timeunit 1ns;
	timeprecision 1ps;
	import apf_pkg::*;
	initial apb_req = '0;
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		logic got;
		@(posedge pclk);
		apb_req <= '{1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge pclk);
			got = apb_rsp.pready;
		end while (!got);
		r = apb_rsp.prdata;
		e = apb_rsp.pslverr;
		apb_req <= '0;
	endtask : xfer
endmodule : apf_apb_master
`default_nettype wire

//--- sim/alu_and_program_flow_tb.sv
`default_nettype none
`include "apf_cfg.svh"
module alu_and_program_flow_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import apf_pkg::*;
	logic pclk, presetn, busy, global_int_en, err;
	apf_apb_req_t apb_req;
	apf_apb_rsp_t apb_rsp;
	int n_errors, n_checks, cyc, i;
	logic [31:0] rdata;
	logic [7:0] a, b, s;
	logic [5:0] op;
	logic [15:0] e, p, m;
	logic [23:0] w;
	logic [5:0] ops [22] = '{0, 1, 3, 4, 5, 6, 8, 9, 10, 11, 12, 13, 14, 15,
		16, 17, 18, 19, 20, 21, 37, 38};
	apf_core apf_core_i (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
		.apb_rsp(apb_rsp), .busy(busy), .global_int_en(global_int_en));
	apf_apb_master apf_apb_master_i (.pclk(pclk), .apb_rsp(apb_rsp),
		.apb_req(apb_req));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic test_done();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : test_done
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_errors++;
			test_done();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		apf_apb_master_i.xfer(1'b1, ad, d, rdata, err);
	endtask : wr
	task automatic rd(input logic [7:0] ad);
		apf_apb_master_i.xfer(1'b0, ad, 32'h0, rdata, err);
	endtask : rd
	task automatic run(input logic [5:0] o, input logic lng);
		int k;
		wr(`APF_OFF_CTRL, {22'h0, 1'b1, lng, 2'b00, o});
		k = 0;
		do begin
			@(negedge pclk);
			k++;
		end while (busy !== 1'b0 && k < 8);
	endtask : run
	function automatic logic [15:0] alu(input logic [5:0] o,
		input logic [7:0] x, input logic [7:0] y, input logic [7:0] f);
		logic [8:0] r;
		logic ci, sb, ar, lg;
		ci = o inside {1, 5, 6, 38} ? f[0] : 1'b0;
		sb = o inside {[3:6], 37, 38};
		ar = o inside {0, 1, [3:6], 37, 38};
		lg = o inside {[8:13], 15, 16, 19, 20};
		case (o)
			8, 9: r = {1'b0, x & y};
			10, 11, 15: r = {1'b0, x | y};
			12: r = {1'b0, x ^ y};
			13: r = {1'b0, ~x};
			14: r = {1'b0, 8'h00 - x};
			16: r = {1'b0, x & ~y};
			17: r = {1'b0, x + 8'h01};
			18: r = {1'b0, x - 8'h01};
			19: r = {1'b0, x};
			20: r = 9'h000;
			21: r = 9'h0ff;
			default: r = sb ? {1'b0, x} - y - ci : x + y + ci;
		endcase
		if (o != 6'd21) begin
			f[1] = r[7:0] == 8'h0 && (o inside {5, 6, 38} ? f[1] : 1'b1);
			f[2] = r[7];
			f[3] = lg ? 1'b0 : ar ? (sb ^ ~(x[7] ^ y[7])) & (r[7] ^ x[7]) :
				r[7:0] == (o == 6'd18 ? 8'h7f : 8'h80);
		end
		if (ar) begin
			f[0] = r[8];
			f[5] = sb ? {1'b0, x[3:0]} < y[3:0] + ci :
				x[3:0] + y[3:0] + ci > 5'hf;
		end
		if (o == 6'd13) f[0] = 1'b1;
		if (o == 6'd14) begin
			f[0] = r[7:0] != 8'h00;
			f[5] = r[3] | x[3];
		end
		return {(o > 6'd36) ? x : r[7:0], f};
	endfunction : alu
	function automatic logic [23:0] word(input logic [5:0] o,
		input logic [15:0] x, input logic [5:0] k, input logic [7:0] f);
		logic [16:0] t;
		t = (o == 6'd2) ? {1'b0, x} + k : {1'b0, x} - k;
		f[0] = t[16];
		f[1] = t[15:0] == 16'h0000;
		f[2] = t[15];
		f[3] = (o == 6'd2) ? ~x[15] & t[15] : x[15] & ~t[15];
		f[4] = f[2] ^ f[3];
		return {t[15:0], f};
	endfunction : word
	function automatic logic [15:0] mul(input logic [5:0] o,
		input logic [7:0] x, input logic [7:0] y);
		int sx, sy;
		sx = o inside {23, 24, 26, 27} ? int'($signed(x)) : int'(x);
		sy = o inside {23, 26} ? int'($signed(y)) : int'(y);
		return 16'(sx * sy);
	endfunction : mul
	initial begin
		presetn = 1'b0;
		n_errors = 0;
		n_checks = 0;
		cyc = 0;
		void'($urandom(32'h6c4caa7a));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(`APF_OFF_SREG);
		chk(rdata, 32'h0);
		for (i = 0; i < 64; i++) begin
			op = (i == 0) ? 6'd0 : (i == 1) ? 6'd14 : ops[$urandom % 22];
			a = (i == 0) ? 8'h7f : (i == 1) ? 8'h80 : 8'($urandom);
			b = (i == 0) ? 8'h01 : 8'($urandom);
			s = 8'($urandom);
			wr(`APF_OFF_OPA, {24'h0, a});
			wr(`APF_OFF_OPB, {24'h0, b});
			wr(`APF_OFF_SREG, {24'h0, s});
			run(op, 1'b0);
			e = alu(op, a, b, s);
			rd(`APF_OFF_OPA);
			chk(rdata, {24'h0, e[15:8]});
			rd(`APF_OFF_SREG);
			chk(rdata, {24'h0, e[7:0]});
		end
		for (i = 0; i < 8; i++) begin
			op = i[0] ? 6'd7 : 6'd2;
			p = (i == 0) ? 16'hffc1 : (i == 1) ? 16'h0000 : 16'($urandom);
			b = (i < 2) ? 8'h3f : 8'($urandom);
			s = 8'($urandom);
			wr(`APF_OFF_OPA, {16'h0, p});
			wr(`APF_OFF_OPB, {24'h0, b});
			wr(`APF_OFF_SREG, {24'h0, s});
			run(op, 1'b0);
			w = word(op, p, b[5:0], s);
			rd(`APF_OFF_OPA);
			chk(rdata, {16'h0, w[23:8]});
			rd(`APF_OFF_SREG);
			chk(rdata, {24'h0, w[7:0]});
		end
		$display("test alu done");
		a = 8'($urandom) | 8'h80;
		b = 8'($urandom);
		p = a * b;
		wr(`APF_OFF_OPA, {24'h0, a});
		wr(`APF_OFF_OPB, {24'h0, b});
		run(6'd22, 1'b0);
		rd(`APF_OFF_PROD);
		chk(rdata, {16'h0, p});
		run(6'd25, 1'b0);
		rd(`APF_OFF_PROD);
		chk(rdata, {16'h0, p << 1});
		rd(`APF_OFF_SREG);
		chk({30'h0, rdata[1:0]}, {30'h0, (p << 1) == 16'h0, p[15]});
		for (i = 22; i < 28; i++) begin
			a = 8'($urandom);
			b = 8'($urandom);
			wr(`APF_OFF_OPA, {24'h0, a});
			wr(`APF_OFF_OPB, {24'h0, b});
			run(6'(i), 1'b0);
			m = mul(6'(i), a, b);
			p = (i > 24) ? m << 1 : m;
			rd(`APF_OFF_PROD);
			chk(rdata, {16'h0, p});
			rd(`APF_OFF_SREG);
			chk({30'h0, rdata[1:0]}, {30'h0, p == 16'h0, m[15]});
		end
		$display("test multiply done");
		wr(`APF_OFF_SREG, 32'h0);
		wr(`APF_OFF_PC, 32'h0100);
		wr(`APF_OFF_OPB, 32'h0005);
		run(6'd28, 1'b0);
		rd(`APF_OFF_PC);
		chk(rdata, 32'h0106);
		wr(`APF_OFF_ZPTR, 32'h0200);
		run(6'd32, 1'b0);
		rd(`APF_OFF_PC);
		chk(rdata, 32'h0200);
		run(6'd33, 1'b0);
		rd(`APF_OFF_STAT);
		chk({28'h0, rdata[7:4]}, 32'h2);
		run(6'd35, 1'b0);
		rd(`APF_OFF_PC);
		chk(rdata, 32'h0202);
		chk({31'h0, global_int_en}, 32'h1);
		run(6'd34, 1'b0);
		rd(`APF_OFF_PC);
		chk(rdata, 32'h0107);
		run(6'd34, 1'b0);
		rd(`APF_OFF_STAT);
		chk({31'h0, rdata[1]}, 32'h1);
		$display("test flow done");
		wr(`APF_OFF_PC, 32'h0010);
		wr(`APF_OFF_OPA, 32'h0005);
		run(6'd36, 1'b1);
		rd(`APF_OFF_PC);
		chk(rdata, 32'h0013);
		rd(`APF_OFF_STAT);
		chk({29'h0, rdata[10:8]}, 32'h3);
		wr(`APF_OFF_OPA, 32'h0006);
		run(6'd36, 1'b0);
		rd(`APF_OFF_PC);
		chk(rdata, 32'h0014);
		wr(`APF_OFF_OPA, 32'h0005);
		run(6'd36, 1'b0);
		rd(`APF_OFF_PC);
		chk(rdata, 32'h0016);
		rd(8'h20);
		chk({err, rdata[30:0]}, 32'h80000000);
		$display("test skip done");
		wr(`APF_OFF_STAT, 32'h0000_0002);
		rd(`APF_OFF_STAT);
		chk({31'h0, rdata[1]}, 32'h0);
		wr(`APF_OFF_ZPTR, 32'h0300);
		run(6'd29, 1'b0);
		rd(`APF_OFF_PC);
		chk(rdata, 32'h0300);
		wr(`APF_OFF_OPB, 32'h0040);
		run(6'd30, 1'b0);
		rd(`APF_OFF_PC);
		chk(rdata, 32'h0040);
		run(6'd31, 1'b0);
		rd(`APF_OFF_PC);
		chk(rdata, 32'h0081);
		run(6'd34, 1'b0);
		rd(`APF_OFF_PC);
		chk(rdata, 32'h0041);
		$display("test jumps done");
		test_done();
	end
endmodule : alu_and_program_flow_tb
`default_nettype wire
